// file: common/mrhs_pkg.sv
// shared constants and types for the reset and hibernate sequencer
package mrhs_pkg;
    localparam int unsigned CLK_HZ          = 40000000;
    localparam int unsigned CYC_PER_MS      = CLK_HZ / 1000;
    // times in milliseconds as specified
    localparam int unsigned RST_MIN_MS      = 5;
    localparam int unsigned RST_PULSE_MS    = 200;
    localparam int unsigned PWR_HOLD_MS     = 200;
    localparam int unsigned HIB_MIN_MS      = 10;
    localparam int unsigned WAKE_TYP_MS     = 50;
    localparam int unsigned WAKE_PATCH_MS   = 75;
    localparam int unsigned WAKE_CAL_MS     = 200;
    // image load: 0.06 ms per kilobyte, kept as microseconds
    localparam int unsigned LOAD_US_PER_KB  = 60;
    localparam int unsigned CYC_PER_US      = CLK_HZ / 1000000;
    localparam int unsigned CAL_TEMP_DELTA  = 20;
    localparam int unsigned CAL_AGE_HOURS   = 24;
    localparam int unsigned LPCLK_HZ        = 32768;
    // age is counted in low-power clock ticks, not seconds
    localparam int unsigned CAL_AGE_LPTICKS = CAL_AGE_HOURS * 3600 * LPCLK_HZ;
    localparam int unsigned CNT_W           = 32;
    localparam int unsigned KB_W            = 16;
    localparam int unsigned TEMP_W          = 8;

    typedef enum logic [2:0] {
        MRHS_DEV_OFF,
        MRHS_DEV_RESET,
        MRHS_DEV_WAKE,
        MRHS_DEV_LOAD,
        MRHS_DEV_RUN,
        MRHS_DEV_HIB
    } mrhs_dev_state_type;

    typedef enum logic [2:0] {
        MRHS_HST_POWERUP,
        MRHS_HST_RELEASE,
        MRHS_HST_WAIT_READY,
        MRHS_HST_IDLE,
        MRHS_HST_RESTART,
        MRHS_HST_HIB,
        MRHS_HST_PWR_HOLD,
        MRHS_HST_PWR_OFF
    } mrhs_hst_state_type;
endpackage

// file: common/mrhs_link_if.sv
// control lines between host sequencer and module
`timescale 1ns/1ps
interface mrhs_link_if;
    logic module_reset_line_n;
    logic hibernate_control_line_n;
    logic module_ready;
    modport host (
        output module_reset_line_n,
        output hibernate_control_line_n,
        input  module_ready
    );
    modport device (
        input  module_reset_line_n,
        input  hibernate_control_line_n,
        output module_ready
    );
endinterface

// file: logic/mrhs_device.sv
// module end: reset acceptance, hibernate, wake-up timing
// What this block and mrhs_host do
// RULE1: reset accepted only after 5 ms low
// RULE2: host holds reset low while supplies ramp
// RULE3: lines steady 200 ms before power removal
// RULE4: restart uses one low pulse, 200 ms
// RULE5: wake-up takes typically 50 ms
// RULE6: image load adds 0.06 ms per kilobyte
// RULE7: calibration stretches wake-up to 200 ms
// RULE8: calibrate on 20 degree shift or 24 h
// RULE9: patch fetch stretches wake-up to 75 ms
// RULE10: low-power clock stays running in hibernate
// RULE11: blackout loses all state, like reset
// RULE12: hibernate ignores brownout, blackout only
// RULE13: host prefers the longer 200 ms pulse
`timescale 1ns/1ps
module mrhs_device #(
    parameter int unsigned CYC_PER_MS = mrhs_pkg::CYC_PER_MS
) (
    input  wire logic                         ref_clk_i,
    input  wire logic                         reset_n_i,
    mrhs_link_if.device                       link,
    input  wire logic                         brownout_i,
    input  wire logic                         blackout_i,
    input  wire logic                         patch_needed_i,
    input  wire logic [mrhs_pkg::KB_W-1:0]    image_kb_i,
    input  wire logic [mrhs_pkg::TEMP_W-1:0]  temperature_i,
    input  wire logic                         lp_tick_i,
    output logic                              operational_o,
    output logic                              hibernating_o,
    output logic                              lp_clk_en_o,
    output logic                              calibrating_o,
    output logic                              brownout_off_o
);
    // link pins and supply monitors come from outside: two flops each
    logic [1:0] rst_sync;
    logic [1:0] hib_sync;
    logic [1:0] bo_sync;
    logic [1:0] blk_sync;
    logic [1:0] tick_sync;
    logic       tick_last;

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_sync  <= 2'h0;
            hib_sync  <= 2'h0;
            bo_sync   <= 2'h0;
            blk_sync  <= 2'h0;
            tick_sync <= 2'h0;
            tick_last <= 1'b0;
        end else begin
            rst_sync  <= {rst_sync[0], link.module_reset_line_n};
            hib_sync  <= {hib_sync[0], link.hibernate_control_line_n};
            bo_sync   <= {bo_sync[0], brownout_i};
            blk_sync  <= {blk_sync[0], blackout_i};
            tick_sync <= {tick_sync[0], lp_tick_i};
            tick_last <= tick_sync[1];
        end
    end

    wire rst_low   = !rst_sync[1];
    wire hib_req   = !hib_sync[1];
    wire blackout  = blk_sync[1];
    wire lp_tick   = tick_sync[1] && !tick_last;

    localparam logic [mrhs_pkg::CNT_W-1:0] RST_MIN_CYC =
        mrhs_pkg::CNT_W'(mrhs_pkg::RST_MIN_MS * CYC_PER_MS);
    localparam logic [mrhs_pkg::CNT_W-1:0] WAKE_TYP_CYC =
        mrhs_pkg::CNT_W'(mrhs_pkg::WAKE_TYP_MS * CYC_PER_MS);
    localparam logic [mrhs_pkg::CNT_W-1:0] WAKE_PATCH_CYC =
        mrhs_pkg::CNT_W'(mrhs_pkg::WAKE_PATCH_MS * CYC_PER_MS);
    localparam logic [mrhs_pkg::CNT_W-1:0] WAKE_CAL_CYC =
        mrhs_pkg::CNT_W'(mrhs_pkg::WAKE_CAL_MS * CYC_PER_MS);
    // load rate follows the millisecond base so a scaled base stays exact
    localparam logic [mrhs_pkg::CNT_W-1:0] LOAD_CYC_PER_KB =
        mrhs_pkg::CNT_W'(mrhs_pkg::LOAD_US_PER_KB * CYC_PER_MS /
        (mrhs_pkg::CYC_PER_MS / mrhs_pkg::CYC_PER_US));
    localparam logic [mrhs_pkg::CNT_W-1:0] CAL_AGE =
        mrhs_pkg::CNT_W'(mrhs_pkg::CAL_AGE_LPTICKS);
    localparam logic [mrhs_pkg::TEMP_W-1:0] CAL_DELTA =
        mrhs_pkg::TEMP_W'(mrhs_pkg::CAL_TEMP_DELTA);

    mrhs_pkg::mrhs_dev_state_type state;
    mrhs_pkg::mrhs_dev_state_type next_state;
    logic [mrhs_pkg::CNT_W-1:0]   rst_cnt;
    logic [mrhs_pkg::CNT_W-1:0]   cnt;
    logic [mrhs_pkg::CNT_W-1:0]   next_cnt;
    logic [mrhs_pkg::CNT_W-1:0]   cal_age;
    logic [mrhs_pkg::TEMP_W-1:0]  cal_temp;
    logic                         cal_valid;
    logic                         cal_run;

    // reset counts only while the line is low; short glitches are ignored
    wire reset_taken = rst_low && (rst_cnt >= RST_MIN_CYC - 1); // RULE1
    // blackout wipes everything in any state, hibernate included
    wire wipe        = blackout || reset_taken; // RULE11
    // brownout drops ready and flags brownout_off_o, keeping the state, except in hibernate
    wire brown_act   = bo_sync[1] &&
                       (state != mrhs_pkg::MRHS_DEV_HIB); // RULE12

    wire [mrhs_pkg::TEMP_W-1:0] t_diff = (temperature_i > cal_temp) ?
        temperature_i - cal_temp : cal_temp - temperature_i;
    wire need_cal = !cal_valid || (t_diff > CAL_DELTA) ||
                    (cal_age > CAL_AGE); // RULE8

    wire [mrhs_pkg::CNT_W-1:0] wake_len =
        need_cal ? WAKE_CAL_CYC :                     // RULE7
        patch_needed_i ? WAKE_PATCH_CYC :             // RULE9
        WAKE_TYP_CYC;                                 // RULE5
    wire [mrhs_pkg::CNT_W-1:0] load_len = mrhs_pkg::CNT_W'(
        {{(mrhs_pkg::CNT_W-mrhs_pkg::KB_W){1'b0}}, image_kb_i} *
        LOAD_CYC_PER_KB); // RULE6

    always_comb begin
        next_state = state;
        next_cnt   = (cnt != '0) ? cnt - 1'b1 : cnt;
        unique case (state)
            mrhs_pkg::MRHS_DEV_OFF,
            mrhs_pkg::MRHS_DEV_RESET: begin
                if (!rst_low && !blackout) begin
                    next_state = mrhs_pkg::MRHS_DEV_WAKE;
                    next_cnt   = wake_len;
                end
            end
            mrhs_pkg::MRHS_DEV_WAKE: begin
                if (cnt == 1) begin
                    next_state = mrhs_pkg::MRHS_DEV_LOAD;
                    next_cnt   = load_len;
                end
            end
            mrhs_pkg::MRHS_DEV_LOAD: begin
                if (cnt <= 1) begin
                    next_state = mrhs_pkg::MRHS_DEV_RUN;
                end
            end
            mrhs_pkg::MRHS_DEV_RUN: begin
                if (hib_req) begin
                    next_state = mrhs_pkg::MRHS_DEV_HIB;
                end
            end
            mrhs_pkg::MRHS_DEV_HIB: begin
                if (!hib_req) begin
                    next_state = mrhs_pkg::MRHS_DEV_WAKE;
                    next_cnt   = wake_len;
                end
            end
        endcase
        if (wipe) begin
            next_state = mrhs_pkg::MRHS_DEV_RESET;
            next_cnt   = '0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            rst_cnt <= '0;
        end else if (rst_low) begin
            rst_cnt <= (rst_cnt != '1) ? rst_cnt + 1'b1 : rst_cnt; // RULE1
        end else begin
            rst_cnt <= '0;
        end
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= mrhs_pkg::MRHS_DEV_OFF;
            cnt   <= '0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
        end
    end

    wire wake_start = (next_state == mrhs_pkg::MRHS_DEV_WAKE) &&
                      (state != mrhs_pkg::MRHS_DEV_WAKE);

    // calibration memory survives hibernate but not a wipe
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            cal_valid <= 1'b0;
            cal_temp  <= '0;
            cal_age   <= '0;
            cal_run   <= 1'b0;
        end else if (wipe) begin
            cal_valid <= 1'b0; // RULE11
            cal_age   <= '0;
            cal_run   <= 1'b0;
        end else if (wake_start && need_cal) begin
            cal_valid <= 1'b1;
            cal_temp  <= temperature_i;
            cal_age   <= '0;
            cal_run   <= 1'b1;
        end else begin
            if (state != mrhs_pkg::MRHS_DEV_WAKE) begin
                cal_run <= 1'b0;
            end
            if (lp_tick && (cal_age != '1)) begin
                cal_age <= cal_age + 1'b1;
            end
        end
    end

    assign link.module_ready = (state == mrhs_pkg::MRHS_DEV_RUN) &&
                               !brown_act;
    assign operational_o     = link.module_ready;
    assign hibernating_o     = (state == mrhs_pkg::MRHS_DEV_HIB);
    // the low-power clock only stops when all state is lost
    assign lp_clk_en_o       = (state != mrhs_pkg::MRHS_DEV_OFF) &&
                               !blackout; // RULE10
    assign calibrating_o     = cal_run;
    assign brownout_off_o    = brown_act; // RULE12
endmodule

// file: logic/mrhs_host.sv
// host end: drives module reset and hibernate control lines
`timescale 1ns/1ps
module mrhs_host #(
    parameter int unsigned CYC_PER_MS = mrhs_pkg::CYC_PER_MS
) (
    input  wire logic  ref_clk_i,
    input  wire logic  reset_n_i,
    mrhs_link_if.host  link,
    input  wire logic  supplies_good_i,
    input  wire logic  restart_req_i,
    input  wire logic  hibernate_req_i,
    input  wire logic  power_down_req_i,
    output logic       power_enable_o,
    output logic       ready_o,
    output logic       timeout_o,
    output logic       busy_o
);
    localparam logic [mrhs_pkg::CNT_W-1:0] PULSE_CYC =
        mrhs_pkg::CNT_W'(mrhs_pkg::RST_PULSE_MS * CYC_PER_MS);
    localparam logic [mrhs_pkg::CNT_W-1:0] HOLD_CYC =
        mrhs_pkg::CNT_W'(mrhs_pkg::PWR_HOLD_MS * CYC_PER_MS);
    localparam logic [mrhs_pkg::CNT_W-1:0] HIB_MIN_CYC =
        mrhs_pkg::CNT_W'(mrhs_pkg::HIB_MIN_MS * CYC_PER_MS);
    localparam int unsigned LOAD_CYC_PER_KB =
        mrhs_pkg::LOAD_US_PER_KB * CYC_PER_MS /
        (mrhs_pkg::CYC_PER_MS / mrhs_pkg::CYC_PER_US);
    // worst case wake (calibration) plus a largest image of 64 MB
    localparam logic [mrhs_pkg::CNT_W-1:0] WAIT_CYC = mrhs_pkg::CNT_W'(
        mrhs_pkg::WAKE_CAL_MS * CYC_PER_MS +
        ((1 << mrhs_pkg::KB_W) - 1) * LOAD_CYC_PER_KB);

    // supply monitor and ready come from other domains
    logic [1:0] sup_sync;
    logic [1:0] rdy_sync;
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            sup_sync <= 2'h0;
            rdy_sync <= 2'h0;
        end else begin
            sup_sync <= {sup_sync[0], supplies_good_i};
            rdy_sync <= {rdy_sync[0], link.module_ready};
        end
    end
    wire sup_ok = sup_sync[1];
    wire rdy    = rdy_sync[1];

    mrhs_pkg::mrhs_hst_state_type state;
    mrhs_pkg::mrhs_hst_state_type next_state;
    logic [mrhs_pkg::CNT_W-1:0]   cnt;
    logic [mrhs_pkg::CNT_W-1:0]   next_cnt;
    logic                         tmo;
    wire cnt_done = (cnt == '0);
    wire wait_expired = (state == mrhs_pkg::MRHS_HST_WAIT_READY) &&
                        cnt_done && !rdy;

    always_comb begin
        next_state = state;
        next_cnt   = cnt_done ? cnt : cnt - 1'b1;
        unique case (state)
            mrhs_pkg::MRHS_HST_POWERUP: begin
                // stay in reset while rails ramp
                if (!sup_ok) begin
                    next_cnt = PULSE_CYC; // RULE2
                end else if (cnt_done) begin
                    next_state = mrhs_pkg::MRHS_HST_RELEASE;
                end
            end
            mrhs_pkg::MRHS_HST_RELEASE: begin
                next_state = mrhs_pkg::MRHS_HST_WAIT_READY;
                next_cnt   = WAIT_CYC; // RULE7
            end
            mrhs_pkg::MRHS_HST_WAIT_READY: begin
                if (rdy || cnt_done) begin
                    next_state = mrhs_pkg::MRHS_HST_IDLE;
                end
            end
            mrhs_pkg::MRHS_HST_IDLE: begin
                if (power_down_req_i) begin
                    next_state = mrhs_pkg::MRHS_HST_PWR_HOLD;
                    next_cnt   = HOLD_CYC;
                end else if (restart_req_i) begin
                    next_state = mrhs_pkg::MRHS_HST_RESTART;
                    // longer pulse covers both minima
                    next_cnt   = PULSE_CYC; // RULE13
                end else if (hibernate_req_i) begin
                    next_state = mrhs_pkg::MRHS_HST_HIB;
                    next_cnt   = HIB_MIN_CYC;
                end
            end
            mrhs_pkg::MRHS_HST_RESTART: begin
                if (cnt_done) begin
                    next_state = mrhs_pkg::MRHS_HST_RELEASE; // RULE4
                end
            end
            mrhs_pkg::MRHS_HST_HIB: begin
                if (cnt_done && !hibernate_req_i) begin
                    next_state = mrhs_pkg::MRHS_HST_RELEASE;
                end else if (cnt_done && power_down_req_i) begin
                    next_state = mrhs_pkg::MRHS_HST_PWR_HOLD;
                    next_cnt   = HOLD_CYC;
                end
            end
            mrhs_pkg::MRHS_HST_PWR_HOLD: begin
                if (cnt_done) begin
                    next_state = mrhs_pkg::MRHS_HST_PWR_OFF; // RULE3
                end
            end
            mrhs_pkg::MRHS_HST_PWR_OFF: begin
                if (!power_down_req_i) begin
                    next_state = mrhs_pkg::MRHS_HST_POWERUP;
                    next_cnt   = PULSE_CYC;
                end
            end
        endcase
    end

    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            state <= mrhs_pkg::MRHS_HST_POWERUP;
            cnt   <= PULSE_CYC;
            tmo   <= 1'b0;
        end else begin
            state <= next_state;
            cnt   <= next_cnt;
            if (wait_expired) begin
                tmo <= 1'b1;
            end else if (state == mrhs_pkg::MRHS_HST_RELEASE) begin
                tmo <= 1'b0;
            end
        end
    end

    wire in_reset = (state == mrhs_pkg::MRHS_HST_POWERUP) ||
                    (state == mrhs_pkg::MRHS_HST_RESTART) ||
                    (state == mrhs_pkg::MRHS_HST_PWR_OFF);
    // in hold both lines are high: reset high, hibernate released even on entry from HIB
    assign link.module_reset_line_n      = !in_reset; // RULE3
    assign link.hibernate_control_line_n =
        (state != mrhs_pkg::MRHS_HST_HIB) &&
        (state != mrhs_pkg::MRHS_HST_PWR_OFF);
    assign power_enable_o = (state != mrhs_pkg::MRHS_HST_PWR_OFF);
    assign ready_o        = (state == mrhs_pkg::MRHS_HST_IDLE) && rdy;
    assign timeout_o      = tmo;
    assign busy_o         = (state != mrhs_pkg::MRHS_HST_IDLE);
endmodule

// file: test/mrhs_link_monitor.sv
// concurrent checks on the host-to-module control lines
`timescale 1ns/1ps
module mrhs_link_monitor #(
    parameter int CYC_PER_MS = mrhs_pkg::CYC_PER_MS
) (
    input  wire logic  ref_clk_i,
    input  wire logic  reset_n_i,
    input  wire logic  module_reset_line_n,
    input  wire logic  hibernate_control_line_n,
    input  wire logic  module_ready
);
    localparam int MS       = CYC_PER_MS;
    localparam int KB_CYC   = mrhs_pkg::LOAD_US_PER_KB * MS /
        (mrhs_pkg::CYC_PER_MS / mrhs_pkg::CYC_PER_US);
    localparam int RST_CYC  = mrhs_pkg::RST_MIN_MS * MS;
    localparam int PULSE    = mrhs_pkg::RST_PULSE_MS * MS;
    localparam int HIB_CYC  = mrhs_pkg::HIB_MIN_MS * MS;
    localparam int WAKE_CYC = mrhs_pkg::WAKE_TYP_MS * MS;
    // worst wake plus the largest image the port can name
    localparam int CEIL_CYC = mrhs_pkg::WAKE_CAL_MS * MS + 65535 * KB_CYC + 8;

    logic [31:0]  low_cnt;
    logic [31:0]  hib_cnt;
    logic [31:0]  hi_cnt;
    wire          both_hi = module_reset_line_n & hibernate_control_line_n;

    // run lengths of reset low, hibernate low and both lines high, each cleared when its level ends
    always_ff @(posedge ref_clk_i or negedge reset_n_i) begin
        if (!reset_n_i) begin
            low_cnt <= '0;
            hib_cnt <= '0;
            hi_cnt  <= '0;
        end else begin
            low_cnt <= module_reset_line_n ? '0 : low_cnt + 32'h1;
            hib_cnt <= hibernate_control_line_n ? '0 : hib_cnt + 32'h1;
            hi_cnt  <= both_hi ? hi_cnt + 32'h1 : '0;
        end
    end

    default clocking cb @(posedge ref_clk_i); endclocking
    default disable iff (!reset_n_i);

    sequence s_ready_up;
        $rose(module_ready);
    endsequence
    sequence s_hib_in;
        $fell(hibernate_control_line_n);
    endsequence
    sequence s_release;
        $rose(module_reset_line_n);
    endsequence

    a_reset_taken: assert property (
        (low_cnt >= RST_CYC + 4) |-> !module_ready)
        else $error("module ready during an accepted reset");
    a_pulse_width: assert property (
        s_release |-> (low_cnt >= PULSE))
        else $error("reset line low pulse shorter than required");
    a_hib_drops_ready: assert property (
        s_hib_in |-> ##[1:4] !module_ready)
        else $error("ready kept after entering hibernate");
    a_hib_no_ready: assert property (
        (hib_cnt > 4) |-> !module_ready)
        else $error("ready seen while hibernating");
    a_hib_min: assert property (
        $rose(hibernate_control_line_n) |-> (hib_cnt >= HIB_CYC))
        else $error("hibernate shorter than its minimum");
    a_wake_floor: assert property (
        s_ready_up |-> (hi_cnt >= WAKE_CYC))
        else $error("ready earlier than the wake time");
    a_wake_ceiling: assert property (
        s_ready_up |-> (hi_cnt <= CEIL_CYC))
        else $error("ready later than the worst wake time");
    a_release_quiet: assert property (
        s_release |-> !module_ready [*8])
        else $error("ready right after reset release");
endmodule

// file: test/module_reset_hibernate_sequencer_tb_top.sv
// self-checking bench: host and module ends joined by one link
`timescale 1ns/1ps
module module_reset_hibernate_sequencer_tb_top;
    // shrunken millisecond base keeps the whole run short
    localparam int MS   = 50;
    localparam int KCYC = mrhs_pkg::LOAD_US_PER_KB * MS /
        (mrhs_pkg::CYC_PER_MS / mrhs_pkg::CYC_PER_US);

    logic         ref_clk, reset_n, supplies_good, restart_req, hib_req;
    logic         pd_req, brownout, blackout, patch, lp_tick;
    logic [15:0]  image_kb;
    logic [7:0]   temperature;
    logic         operational, hibernating, lp_clk_en, calibrating;
    logic         brownout_off, power_enable, host_ready, timeout, busy;
    int           fail_count, n_tests;

    mrhs_link_if mrhs_link_if_i ();
    mrhs_device #(.CYC_PER_MS(MS)) mrhs_device_i (.ref_clk_i(ref_clk),
        .reset_n_i(reset_n),
        .link(mrhs_link_if_i), .brownout_i(brownout), .blackout_i(blackout),
        .patch_needed_i(patch), .image_kb_i(image_kb),
        .temperature_i(temperature), .lp_tick_i(lp_tick),
        .operational_o(operational), .hibernating_o(hibernating),
        .lp_clk_en_o(lp_clk_en), .calibrating_o(calibrating),
        .brownout_off_o(brownout_off));
    mrhs_host #(.CYC_PER_MS(MS)) mrhs_host_i (.ref_clk_i(ref_clk),
        .reset_n_i(reset_n),
        .link(mrhs_link_if_i), .supplies_good_i(supplies_good),
        .restart_req_i(restart_req), .hibernate_req_i(hib_req),
        .power_down_req_i(pd_req), .power_enable_o(power_enable),
        .ready_o(host_ready), .timeout_o(timeout), .busy_o(busy));
    mrhs_link_monitor #(.CYC_PER_MS(MS)) mrhs_link_monitor_i (
        .ref_clk_i(ref_clk),
        .reset_n_i(reset_n),
        .module_reset_line_n(mrhs_link_if_i.module_reset_line_n),
        .hibernate_control_line_n(mrhs_link_if_i.hibernate_control_line_n),
        .module_ready(mrhs_link_if_i.module_ready));

    always #12.5 ref_clk = ~ref_clk;
    // low-power tick near 32.768 kHz keeps calibration age realistic
    always begin
        repeat (610) @(posedge ref_clk);
        lp_tick <= ~lp_tick;
    end

    task automatic wrap_up();
        if (fail_count == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic chk(input string what, input logic [31:0] exp,
                       input logic [31:0] got);
        n_tests++;
        if (got !== exp) begin
            fail_count++;
            $display("[ERR] %s expected %0h seen %0h", what, exp, got);
        end
    endtask

    task automatic chk_in(input string what, input int lo, input int hi,
                          input int got);
        n_tests++;
        if (got < lo || got > hi) begin
            fail_count++;
            $display("[ERR] %s expected %0d..%0d seen %0d", what, lo, hi,
                     got);
        end
    endtask

    function automatic logic probe(input int sel);
        case (sel)
            0: probe = mrhs_link_if_i.module_reset_line_n;
            1: probe = mrhs_link_if_i.module_ready;
            2: probe = mrhs_link_if_i.hibernate_control_line_n;
            3: probe = power_enable;
            default: probe = busy;
        endcase
    endfunction

    // counts edges until the probe shows val; sampled 1 ns after the edge
    task automatic wait_for(input int sel, input logic val, input int limit,
                            output int n);
        n = 0;
        while (probe(sel) !== val && n < limit) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        if (n >= limit) begin
            fail_count++;
            $display("[ERR] wait on probe %0d timed out", sel);
            wrap_up();
        end
    endtask

    task automatic power_up_seq();
        int n;
        repeat (1000) @(posedge ref_clk);
        #1;
        chk("reset line while ramping", 1'b0, probe(0));
        @(posedge ref_clk);
        supplies_good <= 1'b1;
        wait_for(0, 1'b1, 300 * MS, n);
        chk_in("release after supplies", 200 * MS, 200 * MS + 8, n);
        repeat (100) @(posedge ref_clk);
        #1;
        chk("first wake calibrates", 1'b1, calibrating);
        wait_for(1, 1'b1, 250 * MS, n);
        chk_in("first wake", 200 * MS + 3 * KCYC - 100,
               200 * MS + 3 * KCYC - 94, n);
        wait_for(4, 1'b0, 100, n);
        chk("host ready", 1'b1, host_ready);
        chk("host timeout", 1'b0, timeout);
    endtask

    task automatic brown_run();
        int n;
        @(posedge ref_clk);
        brownout <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("brownout flag", 1'b1, brownout_off);
        chk("ready in brownout", 1'b0, operational);
        @(posedge ref_clk);
        brownout <= 1'b0;
        wait_for(1, 1'b1, 20, n);
    endtask

    task automatic hib_patch();
        int n;
        @(posedge ref_clk);
        patch    <= 1'b1;
        image_kb <= 16'h0064;
        hib_req  <= 1'b1;
        wait_for(2, 1'b0, 100, n);
        repeat (8) @(posedge ref_clk);
        #1;
        chk("hibernating", 1'b1, hibernating);
        chk("low-power clock", 1'b1, lp_clk_en);
        @(posedge ref_clk);
        brownout <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("brownout in hibernate", 1'b0, brownout_off);
        chk("state kept", 1'b1, hibernating);
        @(posedge ref_clk);
        brownout <= 1'b0;
        repeat (10 * MS) @(posedge ref_clk);
        hib_req <= 1'b0;
        wait_for(2, 1'b1, 10 * MS, n);
        repeat (100) @(posedge ref_clk);
        #1;
        chk("no calibration", 1'b0, calibrating);
        wait_for(1, 1'b1, 90 * MS, n);
        chk_in("patch wake", 75 * MS + 100 * KCYC - 100,
               75 * MS + 100 * KCYC - 94, n);
        @(posedge ref_clk);
        patch <= 1'b0;
    endtask

    task automatic blackout_restart();
        int n;
        @(posedge ref_clk);
        blackout <= 1'b1;
        repeat (6) @(posedge ref_clk);
        #1;
        chk("ready in blackout", 1'b0, operational);
        chk("clock off in blackout", 1'b0, lp_clk_en);
        @(posedge ref_clk);
        blackout    <= 1'b0;
        restart_req <= 1'b1;
        wait_for(4, 1'b1, 10, n);
        @(posedge ref_clk);
        restart_req <= 1'b0;
        wait_for(0, 1'b0, 10, n);
        wait_for(0, 1'b1, 300 * MS, n);
        chk_in("restart pulse", 200 * MS - 2, 200 * MS + 4, n);
        wait_for(1, 1'b1, 250 * MS, n);
        chk_in("wake after blackout", 200 * MS + 100 * KCYC,
               200 * MS + 100 * KCYC + 6, n);
        wait_for(4, 1'b0, 100, n);
    endtask

    task automatic power_down();
        int n;
        logic r, h;
        @(posedge ref_clk);
        pd_req <= 1'b1;
        wait_for(4, 1'b1, 10, n);
        r = probe(0);
        h = probe(2);
        // lines are judged on the last hold cycle, before power drops
        repeat (200 * MS) @(posedge ref_clk);
        #1;
        chk("reset line steady", r, probe(0));
        chk("hibernate line steady", h, probe(2));
        chk("power on in hold", 1'b1, power_enable);
        wait_for(3, 1'b0, 10, n);
        chk_in("power hold", 200 * MS - 2, 200 * MS + 6, 200 * MS + n);
        @(posedge ref_clk);
        pd_req <= 1'b0;
    endtask

    initial begin
        ref_clk = 1'b0;
        reset_n = 1'b0;
        {supplies_good, restart_req, hib_req, pd_req} = 4'h0;
        {brownout, blackout, patch, lp_tick} = 4'h0;
        image_kb = 16'h0003;
        temperature = 8'h19;
        fail_count = 0;
        n_tests = 0;
        repeat (8) @(posedge ref_clk);
        reset_n <= 1'b1;
        power_up_seq();
        brown_run();
        hib_patch();
        blackout_restart();
        power_down();
        wrap_up();
    end
endmodule
